// File: design/ebc_params.svh
// constants for the external bus, interrupt and reset controller
`ifndef EBC_PARAMS_SVH
`define EBC_PARAMS_SVH
`define EBC_ADDR_W 23
`define EBC_LOW_ADDR_W 16
`define EBC_DATA_W 16
`define EBC_NUM_UINT 4
`define EBC_RESET_VECTOR 23'h00ff80
`define EBC_NMI_VECTOR 16'hff84
`define EBC_UINT_VEC_BASE 16'hffc0
`define EBC_VEC_STEP 16'h0004
`define EBC_REG_AW 3
`define EBC_OFF_CTRL 3'h0
`define EBC_OFF_IMR 3'h1
`define EBC_OFF_IFR 3'h2
`define EBC_OFF_ST 3'h3
`define EBC_OFF_IRQ_STAT 3'h4
`define EBC_OFF_IRQ_CLR 3'h5
`define EBC_OFF_IRQ_EN 3'h6
`define EBC_CTRL_GLOBAL_INTERRUPT_MASK_BIT_BIT 0
`define EBC_CTRL_KEEP_BIT 1
`define EBC_CTRL_RESET 2'h1
`define EBC_EVT_W 3
`define EBC_EVT_ACK_BIT 0
`define EBC_EVT_NMI_BIT 1
`define EBC_EVT_UINT_BIT 2
`endif

// File: design/ebc_pkg.sv
// types shared by the external bus controller files
package ebc_pkg;
    // core side bus request
    typedef struct packed {
        logic active;
        logic write;
        logic prog;
        logic [22:0] addr;
        logic [15:0] wdata;
    } ebc_req_t;
    // interrupt sequencer states
    typedef enum logic [1:0] {
        EBC_RUN = 2'b00,
        EBC_ACK = 2'b01,
        EBC_RST = 2'b10
    } ebc_state_t;
endpackage

// File: design/ebc_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ebc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r; // first stage, read only by second stage
    logic [W-1:0] q_r; // second stage
    // two stage capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= INIT;
            q_r <= INIT;
        end else if (ce_i) begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end
    assign q_o = q_r;
endmodule

// File: design/ebc_top.sv
// external bus pins, interrupt inputs, acknowledge and reset restart logic
`timescale 1ns/1ps
`include "ebc_params.svh"
module ebc_top
    import ebc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // core request
    input wire ebc_req_t req_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    // restart and vector fetch toward the core
    output logic fetch_o,
    output logic [22:0] fetch_addr_o,
    output logic core_run_o,
    // pins
    input wire logic [22:0] addr_pin_i,
    output logic [22:0] addr_pin_o,
    output logic [22:0] addr_pin_oe_n_o,
    input wire logic [15:0] data_pin_i,
    output logic [15:0] data_pin_o,
    output logic [15:0] data_pin_oe_n_o,
    input wire logic host_port_wide_select_i,
    input wire logic output_disable_n_i,
    input wire logic hold_req_n_i,
    output logic hold_ack_n_o,
    input wire logic [3:0] ext_user_interrupt_n_i,
    input wire logic nmi_n_i,
    input wire logic device_reset_n_i,
    output logic interrupt_ack_n_o,
    output logic interrupt_ack_n_oe_n_o,
    // host port view of the pins
    output logic [15:0] host_port_addr_o,
    // register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic irq_o
);
    // synchronised pins: uint[3:0], nmi, reset, hold, wide select, output disable
    logic [7:0] pins_s;
    logic [3:0] uint_n_s;
    logic nmi_n_s;
    logic dev_rst_n_s;
    logic hold_n_s;
    logic wide_s;
    logic odis_n_s;

    ebc_sync #(.W(9), .INIT(9'h1ff)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i({output_disable_n_i, host_port_wide_select_i, hold_req_n_i,
              device_reset_n_i, nmi_n_i, ext_user_interrupt_n_i}),
        .q_o({odis_n_s, pins_s})
    );
    assign uint_n_s = pins_s[3:0];
    assign nmi_n_s = pins_s[4];
    assign dev_rst_n_s = pins_s[5];
    assign hold_n_s = pins_s[6];
    assign wide_s = pins_s[7];

    logic in_reset; // reset pin only, not rst_i
    assign in_reset = ~dev_rst_n_s;

    // control and interrupt registers
    logic [1:0] ctrl_r; // bit0 global_interrupt_mask_bit, bit1 data keeper enable
    logic [3:0] imr_r; // user interrupt mask
    logic [3:0] ifr_r; // user interrupt pending flags
    logic [3:0] uint_prev_r; // last sampled user levels, for edges
    logic nmi_prev_r; // last sampled nmi level
    logic nmi_pend_r; // nmi waiting for service
    logic [2:0] ev_stat_r; // sticky event status
    logic [2:0] ev_en_r; // event interrupt enable
    ebc_state_t state_r;
    ebc_state_t state_nxt;
    logic [15:0] vec_r; // vector being fetched
    logic [1:0] uint_sel; // chosen user interrupt
    logic hold_r; // bus granted away

    // falling edge detection on synchronised inputs
    wire [3:0] uint_fall = uint_prev_r & ~uint_n_s;
    wire nmi_fall = nmi_prev_r & ~nmi_n_s;

    // register write decode
    wire wr_ctrl = reg_wr_i && (reg_addr_i == `EBC_OFF_CTRL);
    wire wr_imr = reg_wr_i && (reg_addr_i == `EBC_OFF_IMR);
    wire wr_ifr = reg_wr_i && (reg_addr_i == `EBC_OFF_IFR);
    wire wr_evclr = reg_wr_i && (reg_addr_i == `EBC_OFF_IRQ_CLR);
    wire wr_even = reg_wr_i && (reg_addr_i == `EBC_OFF_IRQ_EN);
    wire global_interrupt_mask_bit = ctrl_r[`EBC_CTRL_GLOBAL_INTERRUPT_MASK_BIT_BIT];
    wire keep_en = ctrl_r[`EBC_CTRL_KEEP_BIT];

    // masked and prioritised pending user interrupts
    wire [3:0] uint_ready = ifr_r & imr_r;
    wire uint_take = (|uint_ready) && !global_interrupt_mask_bit;
    // lowest number wins
    assign uint_sel = uint_ready[0] ? 2'd0 : uint_ready[1] ? 2'd1 :
                      uint_ready[2] ? 2'd2 : 2'd3;
    wire nmi_take = nmi_pend_r;
    wire take = (state_r == EBC_RUN) && !in_reset && (nmi_take || uint_take);
    wire [15:0] uint_vec = `EBC_UINT_VEC_BASE + (16'(uint_sel) * `EBC_VEC_STEP);
    wire [15:0] vec_nxt = nmi_take ? `EBC_NMI_VECTOR : uint_vec;

    // flag clear mask from a software write, one bit clears one flag
    wire [3:0] ifr_clr = wr_ifr ? reg_wdata_i[3:0] : 4'h0;
    // acknowledge clears the serviced flag
    wire [3:0] ack_clr = (take && !nmi_take) ? (4'h1 << uint_sel) : 4'h0;

    // events: acknowledge, nmi taken, user interrupt flagged
    wire [2:0] ev_set = {|uint_fall, take && nmi_take, take};

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            EBC_RST: begin
                if (!in_reset) begin
                    state_nxt = EBC_RUN;
                end
            end
            EBC_RUN: begin
                if (in_reset) begin
                    state_nxt = EBC_RST;
                end else if (take) begin
                    state_nxt = EBC_ACK;
                end
            end
            EBC_ACK: begin
                state_nxt = in_reset ? EBC_RST : EBC_RUN;
            end
            default: begin
                state_nxt = EBC_RST;
            end
        endcase
    end

    // state, vector and edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= EBC_RST;
            vec_r <= 16'h0000;
            uint_prev_r <= 4'hf;
            nmi_prev_r <= 1'b1;
            hold_r <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            uint_prev_r <= uint_n_s;
            nmi_prev_r <= nmi_n_s;
            hold_r <= ~hold_n_s;
            if (take) begin
                vec_r <= vec_nxt;
            end
        end
    end

    // pending flags, set wins over clear
    // reset pin reinitialises flags, mask, control and nmi pending; event status and enables kept
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && in_reset)) begin
            ifr_r <= 4'h0;
            imr_r <= 4'h0;
            ctrl_r <= `EBC_CTRL_RESET;
            nmi_pend_r <= 1'b0;
        end else if (ce_i) begin
            ifr_r <= (ifr_r & ~ifr_clr & ~ack_clr) | uint_fall;
            nmi_pend_r <= nmi_fall || (nmi_pend_r && !take);
            if (wr_imr) begin
                imr_r <= reg_wdata_i[3:0];
            end
            if (wr_ctrl) begin
                // a taken interrupt still sets global_interrupt_mask_bit over a software write
                ctrl_r <= reg_wdata_i[1:0] | {1'b0, take};
            end else if (take) begin
                // taking an interrupt sets global_interrupt_mask_bit
                ctrl_r[`EBC_CTRL_GLOBAL_INTERRUPT_MASK_BIT_BIT] <= 1'b1;
            end
        end
    end

    // sticky event status, set wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_stat_r <= 3'h0;
            ev_en_r <= 3'h0;
        end else if (ce_i) begin
            ev_stat_r <= (ev_stat_r & ~(wr_evclr ? reg_wdata_i[2:0] : 3'h0)) | ev_set;
            if (wr_even) begin
                ev_en_r <= reg_wdata_i[2:0];
            end
        end
    end
    assign irq_o = |(ev_stat_r & ev_en_r);

    // register read mux
    wire [15:0] rd_mux = (reg_addr_i == `EBC_OFF_CTRL) ? {14'h0, ctrl_r} :
                         (reg_addr_i == `EBC_OFF_IMR) ? {12'h0, imr_r} :
                         (reg_addr_i == `EBC_OFF_IFR) ? {12'h0, ifr_r} :
                         (reg_addr_i == `EBC_OFF_ST) ? {12'h0, hold_r, wide_s,
                                                        state_r} :
                         (reg_addr_i == `EBC_OFF_IRQ_STAT) ? {13'h0, ev_stat_r} :
                         (reg_addr_i == `EBC_OFF_IRQ_EN) ? {13'h0, ev_en_r} :
                         16'h0000;
    logic [15:0] reg_rdata_r;
    // read data one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_r <= 16'h0000;
        end else if (ce_i) begin
            reg_rdata_r <= reg_rd_i ? rd_mux : 16'h0000;
        end
    end
    assign reg_rdata_o = reg_rdata_r;

    // core bus drive, address and data registers
    logic [22:0] addr_r;
    logic [15:0] wdata_r;
    logic rd_pend_r; // read address goes out, data due at the next edge
    logic drive_data_r;
    logic ack_r;
    logic [15:0] rdata_r;
    logic rvalid_r;
    wire can_drive = !hold_r && odis_n_s;
    // high lines only in program space
    wire [22:0] bus_addr = (state_r == EBC_ACK) ? {7'h00, vec_r} :
                           req_i.prog ? req_i.addr : {7'h00, req_i.addr[15:0]};
    wire bus_go = req_i.active && !in_reset && (state_r == EBC_RUN);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_r <= 23'h000000;
            wdata_r <= 16'h0000;
            rd_pend_r <= 1'b0;
            drive_data_r <= 1'b0;
            ack_r <= 1'b0;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end else if (ce_i) begin
            // address keeps last level while released
            if (bus_go || state_r == EBC_ACK) begin
                addr_r <= bus_addr;
            end
            // data driven only on a write
            drive_data_r <= bus_go && req_i.write;
            // sample read data once the address has been on the pins a cycle
            rd_pend_r <= bus_go && !req_i.write;
            rvalid_r <= rd_pend_r;
            if (rd_pend_r) begin
                rdata_r <= data_pin_i;
            end
            // keeper holds written value when enabled
            if (bus_go && req_i.write) begin
                wdata_r <= req_i.wdata;
            end else if (!keep_en) begin
                wdata_r <= 16'h0000;
            end
            ack_r <= (state_r == EBC_ACK);
        end
    end
    assign rdata_o = rdata_r;
    assign rvalid_o = rvalid_r;

    // release address in hold or disable; low lines inputs in wide mode
    wire addr_low_en = can_drive && !wide_s && !in_reset;
    wire addr_high_en = can_drive && !in_reset;
    assign addr_pin_o = addr_r;
    assign addr_pin_oe_n_o = {{7{~addr_high_en}}, {16{~addr_low_en}}};
    assign host_port_addr_o = wide_s ? addr_pin_i[15:0] : 16'h0000;

    // data enable gated by reset, hold and disable
    wire data_en = drive_data_r && can_drive && !in_reset;
    assign data_pin_o = wdata_r;
    assign data_pin_oe_n_o = {16{~data_en}};

    assign interrupt_ack_n_o = ~ack_r;
    assign interrupt_ack_n_oe_n_o = ~odis_n_s;
    assign hold_ack_n_o = ~hold_r;

    // reset vector loaded; first fetch on release
    assign fetch_o = (state_r == EBC_RST && !in_reset) || (state_r == EBC_ACK);
    assign fetch_addr_o = (state_r == EBC_ACK) ? {7'h00, vec_r} : `EBC_RESET_VECTOR;
    assign core_run_o = (state_r != EBC_RST);
endmodule

// File: verif/ebc_top_properties.sv
// pin timing properties of the external bus controller
`timescale 1ns/1ps
`include "ebc_params.svh"
module ebc_chk
    import ebc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ebc_req_t req_i,
    input wire logic fetch_o,
    input wire logic [22:0] fetch_addr_o,
    input wire logic core_run_o,
    input wire logic [22:0] addr_pin_o,
    input wire logic [22:0] addr_pin_oe_n_o,
    input wire logic [15:0] data_pin_oe_n_o,
    input wire logic host_port_wide_select_i,
    input wire logic output_disable_n_i,
    input wire logic hold_req_n_i,
    input wire logic hold_ack_n_o,
    input wire logic nmi_n_i,
    input wire logic interrupt_ack_n_o,
    input wire logic interrupt_ack_n_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // request the bus side accepts this cycle
    wire tk = req_i.active && core_run_o && !fetch_o && hold_ack_n_o;
    a_addr_float: assert property (!output_disable_n_i [*4] |-> &addr_pin_oe_n_o)
        else $error("address driven while outputs disabled");
    a_hold_float: assert property (!hold_req_n_i [*4] |-> &addr_pin_oe_n_o && &data_pin_oe_n_o)
        else $error("bus driven during hold");
    a_data_write: assert property (!data_pin_oe_n_o[0] |-> $past(req_i.active && req_i.write))
        else $error("data driven without a write");
    a_space_upper: assert property (tk && !req_i.prog |=> addr_pin_o[22:16] == 7'h00)
        else $error("upper address set outside program space");
    a_low_shared: assert property (tk |=> addr_pin_o[15:0] == $past(req_i.addr[15:0]))
        else $error("low address lines wrong");
    a_host_input: assert property (host_port_wide_select_i [*4] |-> &addr_pin_oe_n_o[15:0])
        else $error("low address driven in wide host mode");
    a_ack_pulse: assert property ($fell(interrupt_ack_n_o) |=> interrupt_ack_n_o)
        else $error("acknowledge longer than one cycle");
    a_interrupt_ack_n_float: assert property (!output_disable_n_i [*4] |-> interrupt_ack_n_oe_n_o)
        else $error("acknowledge driven while outputs disabled");
    a_nmi_serve: assert property ($fell(nmi_n_i) && core_run_o |-> ##[2:12] !interrupt_ack_n_o)
        else $error("nonmaskable interrupt not served");
    a_reset_vec: assert property (fetch_o && !core_run_o |-> fetch_addr_o == `EBC_RESET_VECTOR)
        else $error("restart address wrong");
    cover property (!interrupt_ack_n_o);
    cover property (tk && req_i.write);
    cover property (host_port_wide_select_i [*4]);
endmodule

// File: verif/ebc_mem_model.sv
// external memory on the far side of the data bus
`timescale 1ns/1ps
module ebc_mem_model
    import ebc_pkg::*;
(
    input wire logic clk_i,
    input wire ebc_req_t req_i,
    input wire logic [22:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] oe_n_i,
    output logic [15:0] rdata_o
);
    logic [15:0] mem_r [16]; // word store on low address bits
    logic [15:0] last_r = '0; // last level seen on the bus
    logic [1:0] rd_cnt_r = '0; // cycles left to drive a read
    // memory data while a read runs, else the inverse of the last level
    assign rdata_o = (rd_cnt_r != 2'h0) ? mem_r[addr_i[3:0]] : ~last_r;
    // capture writes and count read cycles
    always_ff @(posedge clk_i) begin
        rd_cnt_r <= (req_i.active && !req_i.write) ? 2'h1 : rd_cnt_r - 2'(rd_cnt_r != 2'h0);
        last_r <= rdata_o;
        if (!oe_n_i[0]) begin
            mem_r[addr_i[3:0]] <= wdata_i;
        end
    end
endmodule

// File: verif/ebc_top_test.sv
// self-checking bench for the external bus controller
`timescale 1ns/1ps
`include "ebc_params.svh"
module ebc_top_test;
    import ebc_pkg::*;
    logic clk_i = 0, rst_i = 1, ce_i = 1, wide = 0, dis_n = 1, hold_n = 1, nmi_n = 1, dev_n = 0;
    logic reg_wr_i = 0, reg_rd_i = 0;
    ebc_req_t req_i = '0;
    logic [22:0] host_a = '0, ta = '0;
    logic [15:0] reg_wdata_i = '0;
    logic [15:0] sb [16];
    logic [3:0] uint_n = 4'hf;
    logic [2:0] reg_addr_i = '0;
    wire logic [22:0] addr_pin_o, addr_oe_n, addr_pin_i, fetch_addr_o;
    wire logic [15:0] rdata_o, data_pin_o, data_oe_n, data_pin_i, mdata, host_port_addr_o;
    wire logic [15:0] reg_rdata_o;
    wire logic rvalid_o, fetch_o, core_run_o, interrupt_ack_n_n, irq_o, hold_ack_n, interrupt_ack_n_oe_n;
    int n_mismatch = 0, n_tests = 0, seed = 32'hf980d560;
    always #4 clk_i = ~clk_i;
    // wire levels from all drivers
    assign addr_pin_i = (addr_pin_o & ~addr_oe_n) | (host_a & addr_oe_n);
    assign data_pin_i = data_oe_n[0] ? mdata : data_pin_o;
    ebc_top dut_u (.clk_i, .rst_i, .ce_i, .req_i, .rdata_o, .rvalid_o, .fetch_o, .fetch_addr_o,
        .core_run_o, .addr_pin_i, .addr_pin_o, .addr_pin_oe_n_o(addr_oe_n), .data_pin_i,
        .data_pin_o, .data_pin_oe_n_o(data_oe_n), .host_port_wide_select_i(wide),
        .output_disable_n_i(dis_n), .hold_req_n_i(hold_n), .hold_ack_n_o(hold_ack_n),
        .ext_user_interrupt_n_i(uint_n), .nmi_n_i(nmi_n), .device_reset_n_i(dev_n),
        .interrupt_ack_n_o(interrupt_ack_n_n), .interrupt_ack_n_oe_n_o(interrupt_ack_n_oe_n),
        .host_port_addr_o, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);
    ebc_mem_model mem_u (.clk_i, .req_i, .addr_i(addr_pin_o), .wdata_i(data_pin_o),
        .oe_n_i(data_oe_n), .rdata_o(mdata));
    task automatic chk(input string nm, input logic [22:0] exp, input logic [22:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 0;
        #1 chk("reg", {7'h0, exp}, {7'h0, reg_rdata_o});
    endtask
    // one core transfer, read data compared with the scoreboard
    task automatic bus(input logic w, input logic p, input logic [22:0] a, input logic [15:0] d);
        @(posedge clk_i);
        req_i <= '{1'b1, w, p, a, d};
        if (w) sb[a[3:0]] = d;
        @(posedge clk_i);
        req_i <= '0;
        #1 chk("addr", p ? a : {7'h0, a[15:0]}, addr_pin_o);
        chk("doe", w ? 23'h0 : 23'hffff, {7'h0, data_oe_n});
        if (w) chk("wdata", {7'h0, d}, {7'h0, data_pin_o});
        if (!w) begin
            chk("dkeep", {7'h0, sb[a[3:0]]}, {7'h0, data_pin_o});
            repeat (6) begin
                if (rvalid_o === 1'b1) break;
                @(posedge clk_i);
                #1;
            end
            chk("rvalid", 23'h1, {22'h0, rvalid_o});
            chk("rdata", {7'h0, sb[a[3:0]]}, {7'h0, rdata_o});
        end
    endtask
    task automatic irq(input int n, input logic [15:0] vec, input logic want);
        logic seen;
        seen = 0;
        @(posedge clk_i);
        if (n < 4) uint_n[n] <= 0;
        else nmi_n <= 0;
        repeat (12) begin
            @(posedge clk_i);
            #1;
            if (interrupt_ack_n_n === 1'b0) begin
                seen = 1;
                chk("vector", {7'h0, vec}, addr_pin_o);
            end
        end
        uint_n <= 4'hf;
        nmi_n <= 1;
        chk("ack", {22'h0, want}, {22'h0, seen});
    endtask
    task automatic restart();
        dev_n <= 0;
        cyc(5);
        #1 chk("run", 23'h0, {22'h0, core_run_o});
        chk("doe", 23'hffff, {7'h0, data_oe_n});
        dev_n <= 1;
        repeat (10) begin
            @(posedge clk_i);
            #1;
            if (fetch_o === 1'b1) break;
        end
        chk("fetch", 23'h1, {22'h0, fetch_o});
        chk("restart", `EBC_RESET_VECTOR, fetch_addr_o);
        rd(3'h0, 16'h0001);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial begin
        cyc(10);
        rst_i <= 0;
        restart();
        wr(3'h7, 16'hffff);
        rd(3'h7, 16'h0000);
        wr(3'h0, 16'h0002);
        rd(3'h0, 16'h0002);
        for (int i = 0; i < 12; i++) begin
            ta = 23'($random(seed)) & 23'h7f000f;
            bus(1, 1'($random(seed)), ta, 16'($random(seed)));
            bus(0, i[0], ta, 16'h0);
        end
        wr(3'h1, 16'h000f);
        wr(3'h6, 16'h0007);
        for (int n = 0; n < 4; n++) begin
            wr(3'h0, 16'h0002);
            irq(n, `EBC_UINT_VEC_BASE + 16'(n * 4), 1);
            rd(3'h2, 16'h0000);
        end
        chk("irq", 23'h1, {22'h0, irq_o});
        wr(3'h5, 16'h0007);
        #1 chk("irq", 23'h0, {22'h0, irq_o});
        wr(3'h1, 16'h0000);
        wr(3'h0, 16'h0002);
        irq(0, 16'h0, 0);
        rd(3'h2, 16'h0001);
        wr(3'h2, 16'h0001);
        rd(3'h2, 16'h0000);
        wr(3'h0, 16'h0003);
        irq(4, `EBC_NMI_VECTOR, 1);
        hold_n <= 0;
        cyc(6);
        #1 chk("hold", 23'h7fffff, addr_oe_n);
        chk("holdack", 23'h0, {22'h0, hold_ack_n});
        chk("akeep", {7'h0, `EBC_NMI_VECTOR}, addr_pin_o);
        hold_n <= 1;
        dis_n <= 0;
        host_a <= 23'($random(seed));
        wide <= 1;
        cyc(6);
        #1 chk("off", 23'h7fffff, addr_oe_n);
        chk("iackoe", 23'h1, {22'h0, interrupt_ack_n_oe_n});
        dis_n <= 1;
        cyc(4);
        #1 chk("host", {7'h0, host_a[15:0]}, {7'h0, host_port_addr_o});
        wide <= 0;
        restart();
        print_verdict();
    end
    // watchdog against a hang
    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end
endmodule
bind ebc_top ebc_chk chk_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(req_i),
    .fetch_o(fetch_o),
    .fetch_addr_o(fetch_addr_o),
    .core_run_o(core_run_o),
    .addr_pin_o(addr_pin_o),
    .addr_pin_oe_n_o(addr_pin_oe_n_o),
    .data_pin_oe_n_o(data_pin_oe_n_o),
    .host_port_wide_select_i(host_port_wide_select_i),
    .output_disable_n_i(output_disable_n_i),
    .hold_req_n_i(hold_req_n_i),
    .hold_ack_n_o(hold_ack_n_o),
    .nmi_n_i(nmi_n_i),
    .interrupt_ack_n_o(interrupt_ack_n_o),
    .interrupt_ack_n_oe_n_o(interrupt_ack_n_oe_n_o)
);
